/* verilog/ipl_pkg.sv */
// Shared types and constants for the integer pipeline interlock block.
// Assumes a single core clock and a decode stage that presents one
// instruction descriptor per cycle.
package ipl_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int IPL_DATA_W = 32;
  localparam int IPL_IDX_W  = 4;
  localparam int IPL_CNT_W  = 4;

  // ---------------------------------------------------------------
  // Timing counts, in core cycles
  // ---------------------------------------------------------------
  localparam logic [3:0] IPL_BEATS_PER_CYC = 4'h2;  // Registers per load-multiple beat.
  localparam logic [3:0] IPL_REFILL_CYC    = 4'h6;  // Refill after a multiple load of the pc.
  localparam logic [3:0] IPL_SWAP_CYC      = 4'h2;
  localparam logic [3:0] IPL_BLH1_CYC      = 4'h3;
  localparam logic [3:0] IPL_BLH2_CYC      = 4'h4;
  localparam logic [3:0] IPL_SOFT_INT_PASS_CYC = 4'h5;
  localparam logic [3:0] IPL_SOFT_INT_FAIL_CYC = 4'h2;
  localparam logic [3:0] IPL_BR_EMPTY_CYC  = 4'h3;
  localparam logic [3:0] IPL_LSM_FAIL_CYC  = 4'h1;
  localparam logic [3:0] IPL_LSMPC_FAIL_CYC = 4'h2;
  localparam logic [1:0] IPL_LOAD_USE_CYC  = 2'h1;
  localparam logic [1:0] IPL_BYTE_USE_CYC  = 2'h2;
  localparam logic [1:0] IPL_ADDR_DP_CYC   = 2'h1;
  localparam logic [1:0] IPL_ADDR_LD_CYC   = 2'h2;

  // ---------------------------------------------------------------
  // Instruction classes seen by the interlock logic
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    IPL_DP     = 4'h0,
    IPL_LOAD   = 4'h1,  // single_register_load
    IPL_BYTE   = 4'h2,  // byte_load
    IPL_STORE  = 4'h3,
    IPL_LOAD_MULTI  = 4'h4,  // load_multiple
    IPL_STORE_MULTI = 4'h5,  // store_multiple
    IPL_SWAP   = 4'h6,  // atomic_swap_word or atomic_swap_byte
    IPL_MUL    = 4'h7,
    IPL_MAC    = 4'h8,
    IPL_CP     = 4'h9,
    IPL_BLH1   = 4'hA,  // First half of a compact branch_with_link.
    IPL_BLH2   = 4'hB,  // Second half of a compact branch_with_link.
    IPL_SOFT_INT = 4'hC,  // software_interrupt
    IPL_BRANCH = 4'hD
  } ipl_cls_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_MULTI  = 3'h1,
    ST_REFILL = 3'h2,
    ST_FIXED  = 3'h3,
    ST_COPROC = 3'h4
  } ipl_state_type;

  // Decode-stage instruction descriptor.
  typedef struct packed {
    logic                 valid;
    ipl_cls_type          cls;
    logic [IPL_IDX_W-1:0] src_a;     // First operand, or address base.
    logic [IPL_IDX_W-1:0] src_b;
    logic [IPL_IDX_W-1:0] dst;
    logic [4:0]           nregs;     // Register list length, 1 to 16.
    logic                 aligned;   // First access 64-bit aligned.
    logic                 has_pc;    // List includes the program_counter.
    logic                 cond_pass;
    logic                 folded;    // Branch already folded by prefetch.
    logic                 acc_dep;   // Accumulate operand not yet produced.
  } ipl_dec_type;

  // One register bank write port.
  typedef struct packed {
    logic                  en;
    logic [IPL_IDX_W-1:0]  idx;
    logic [IPL_DATA_W-1:0] data;
  } ipl_wr_type;

endpackage : ipl_pkg

/* verilog/ipl_regbank.sv */
// Register bank with four read ports and three write ports.
// Assumes writes arrive at the end of the write stage on the core clock.
`timescale 1ns/100ps

module ipl_regbank #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 32
) (
  input  wire logic                     i_clk,
  input  wire logic [$clog2(DEPTH)-1:0] i_rd_idx_a,
  input  wire logic [$clog2(DEPTH)-1:0] i_rd_idx_b,
  input  wire logic [$clog2(DEPTH)-1:0] i_rd_idx_st1,
  input  wire logic [$clog2(DEPTH)-1:0] i_rd_idx_st2,
  input  wire ipl_pkg::ipl_wr_type      i_wr_alu,
  input  wire ipl_pkg::ipl_wr_type      i_wr_load_first,
  input  wire ipl_pkg::ipl_wr_type      i_wr_load_second,
  output logic [WIDTH-1:0]              o_rd_a,
  output logic [WIDTH-1:0]              o_rd_b,
  output logic [WIDTH-1:0]              o_rd_st1,
  output logic [WIDTH-1:0]              o_rd_st2
);
  import ipl_pkg::*;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (DEPTH != (1 << IPL_IDX_W) || WIDTH != IPL_DATA_W)
  begin : g_bad_param
    $error("ipl_regbank: DEPTH and WIDTH must match the package widths.");
  end

  logic [WIDTH-1:0] bank_reg [DEPTH];
  ipl_wr_type       wr_port [3];

  // ---------------------------------------------------------------
  // Write ports
  // ---------------------------------------------------------------
  assign wr_port[0] = i_wr_alu;
  assign wr_port[1] = i_wr_load_first;
  assign wr_port[2] = i_wr_load_second;

  // two load-store writes.
  // Later ports win a same-register collision, so loaded data beats base write-back.
  always_ff @(posedge i_clk)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (wr_port[p].en)
        bank_reg[wr_port[p].idx] <= wr_port[p].data;
    end
  end

  // ---------------------------------------------------------------
  // Read ports
  // ---------------------------------------------------------------
  // decode read ports and store-data read ports.
  assign o_rd_a  = bank_reg[i_rd_idx_a];
  assign o_rd_b  = bank_reg[i_rd_idx_b];
  assign o_rd_st1 = bank_reg[i_rd_idx_st1];
  assign o_rd_st2 = bank_reg[i_rd_idx_st2];

endmodule : ipl_regbank

/* verilog/ipl_interlock.sv */
// Pipeline interlock, sequencing and operand forwarding for the integer core.
// Assumes the load/store unit, multiplier, prefetch unit and coprocessor
// run on the same core clock and report their state with plain levels.
`timescale 1ns/100ps

// Overview of operation
// - Load-multiple moves two registers per cycle.
// - Multiples iterate once per transfer until done.
// - Later instructions wait while multiple is active.
// - Pc in load-multiple adds six refill cycles.
// - Swap waits for drain, then takes two.
// - Coprocessor work stalls until coprocessor ready.
// - First branch-with-link half takes three cycles.
// - Second branch-with-link half takes four cycles.
// - Software interrupt five cycles, two when failing.
// - Folded branch free; empty prefetch costs three.
// - Forward when possible, otherwise stall in hardware.
// - Use of load result stalls one cycle.
// - Address after data processing stalls one cycle.
// - Address after single load stalls two cycles.
// - Multiply waits for multiplier first stage free.
// - Accumulate stalls late, only when value needed.
// - Results forwarded the cycle after calculation.
// - Two decode read ports for operands, addresses.
// - Two execute read ports for store data.
// - One write port for integer unit results.
// - Two load write ports at write end.
// - Use of byte load stalls two cycles.
module ipl_interlock (
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_n,
  input  wire ipl_pkg::ipl_dec_type              i_dec,
  input  wire logic                              i_ldst_pending,
  input  wire logic                              i_mul_head_busy,
  input  wire logic                              i_acc_ready,
  input  wire logic                              i_cp_ready,
  input  wire logic                              i_pfu_empty,
  input  wire logic [ipl_pkg::IPL_DATA_W-1:0]    i_ex_result,
  input  wire logic [ipl_pkg::IPL_DATA_W-1:0]    i_mem_result,
  input  wire ipl_pkg::ipl_wr_type               i_alu_wr,
  input  wire ipl_pkg::ipl_wr_type               i_ldst_wr_first,
  input  wire ipl_pkg::ipl_wr_type               i_ldst_wr_second,
  input  wire logic [ipl_pkg::IPL_IDX_W-1:0]     i_store_idx_first,
  input  wire logic [ipl_pkg::IPL_IDX_W-1:0]     i_store_idx_second,
  output logic                                   o_issue,
  output logic                                   o_stall_decode,
  output logic                                   o_bubble,
  output logic                                   o_ex_hold,
  output logic                                   o_lsm_active,
  output logic                                   o_refill,
  output ipl_pkg::ipl_dec_type                   o_ex_instr,
  output logic [ipl_pkg::IPL_DATA_W-1:0]         o_op_a,
  output logic [ipl_pkg::IPL_DATA_W-1:0]         o_op_b,
  output logic [ipl_pkg::IPL_DATA_W-1:0]         o_store_data_first,
  output logic [ipl_pkg::IPL_DATA_W-1:0]         o_store_data_second
);
  import ipl_pkg::*;

  // ---------------------------------------------------------------
  // Class helpers
  // ---------------------------------------------------------------
  function automatic logic is_dp(input ipl_cls_type c);
    return c inside {IPL_DP, IPL_MUL, IPL_MAC, IPL_BLH1, IPL_BLH2};
  endfunction : is_dp

  function automatic logic is_ls(input ipl_cls_type c);
    return c inside {IPL_LOAD, IPL_BYTE, IPL_STORE, IPL_LOAD_MULTI, IPL_STORE_MULTI, IPL_SWAP};
  endfunction : is_ls

  // Cycles a multiple spends in the load-store unit, two registers per beat,
  // one lone register first when the start is not 64-bit aligned.
  function automatic logic [IPL_CNT_W-1:0] lsm_beats(input logic [4:0] n, input logic al);
    logic [4:0] b;
    b = al ? 5'((n + 5'(IPL_BEATS_PER_CYC) - 5'h1) >> 1) : 5'(5'h1 + (n >> 1));
    return (b == 5'h0) ? 4'h1 : b[IPL_CNT_W-1:0];
  endfunction : lsm_beats

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_n_reg;

  // The release is synchronised so that all state leaves reset on one edge.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_reg   <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg   <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ipl_state_type        state_reg,  state_next;
  logic [IPL_CNT_W-1:0] cnt_reg,    cnt_next;
  logic                 pc_reg,     pc_next;
  logic [1:0]           waited_reg, waited_next;
  ipl_dec_type          prev_reg;
  ipl_dec_type          ex_reg;
  ipl_dec_type          mem_reg;
  logic [IPL_DATA_W-1:0] op_a_reg, op_b_reg, st1_reg, st2_reg;

  // ---------------------------------------------------------------
  // Data dependency detection
  // ---------------------------------------------------------------
  wire prev_load  = prev_reg.valid && prev_reg.cls == IPL_LOAD;
  wire prev_byte  = prev_reg.valid && prev_reg.cls == IPL_BYTE;
  wire prev_dp    = prev_reg.valid && is_dp(prev_reg.cls);
  wire src_hit    = i_dec.src_a == prev_reg.dst || i_dec.src_b == prev_reg.dst;
  wire addr_hit   = i_dec.src_a == prev_reg.dst;
  wire dp_now     = i_dec.valid && is_dp(i_dec.cls);
  wire ls_now     = i_dec.valid && is_ls(i_dec.cls);
  wire dp_hit     = dp_now && src_hit;
  logic [1:0] dep_need;

  // hardware stall where forwarding is late.
  always_comb
  begin
    dep_need = 2'h0;
    if (dp_hit && prev_load)
      dep_need = IPL_LOAD_USE_CYC;
    if (dp_hit && prev_byte)
      dep_need = IPL_BYTE_USE_CYC;
    if (ls_now && addr_hit && prev_dp)
      dep_need = IPL_ADDR_DP_CYC;
    if (ls_now && addr_hit && (prev_load || prev_byte))
      dep_need = IPL_ADDR_LD_CYC;
  end

  // ---------------------------------------------------------------
  // Stall and issue decisions
  // ---------------------------------------------------------------
  wire fsm_busy  = state_reg != ST_IDLE;
  wire dep_wait  = waited_reg < dep_need;
  wire mul_wait  = i_dec.cls inside {IPL_MUL, IPL_MAC} && i_mul_head_busy;
  wire swap_wait = i_dec.cls == IPL_SWAP && i_ldst_pending;
  wire acc_hold  = ex_reg.valid && ex_reg.cls == IPL_MAC && ex_reg.acc_dep && !i_acc_ready;

  assign o_stall_decode = i_dec.valid && (fsm_busy || acc_hold || dep_wait || mul_wait
                                          || swap_wait);
  assign o_issue        = i_dec.valid && !o_stall_decode;
  assign o_ex_hold      = acc_hold;
  assign o_bubble       = !o_issue && !acc_hold;
  assign o_lsm_active   = state_reg == ST_MULTI;
  assign o_refill       = state_reg == ST_REFILL;
  assign o_ex_instr     = ex_reg;

  // Stall cycles already spent count toward the dependency wait.
  assign waited_next = o_issue ? 2'h0 :
                       (o_stall_decode && waited_reg != 2'h3) ? 2'(waited_reg + 2'h1) :
                       waited_reg;

  // ---------------------------------------------------------------
  // Multi-cycle sequencer
  // ---------------------------------------------------------------
  wire [IPL_CNT_W-1:0] beats = lsm_beats(i_dec.nregs, i_dec.aligned);
  logic [IPL_CNT_W-1:0] fix_cyc;

  always_comb
  begin
    fix_cyc = 4'h1;
    unique case (i_dec.cls)
      IPL_BLH1:   fix_cyc = IPL_BLH1_CYC;
      IPL_BLH2:   fix_cyc = IPL_BLH2_CYC;
      IPL_SOFT_INT: fix_cyc = i_dec.cond_pass ? IPL_SOFT_INT_PASS_CYC : IPL_SOFT_INT_FAIL_CYC;
      IPL_SWAP:   fix_cyc = IPL_SWAP_CYC;
      IPL_BRANCH: fix_cyc = (!i_dec.folded && i_pfu_empty) ? IPL_BR_EMPTY_CYC : 4'h1;
      IPL_LOAD_MULTI,
      IPL_STORE_MULTI: fix_cyc = i_dec.has_pc ? IPL_LSMPC_FAIL_CYC : IPL_LSM_FAIL_CYC;
      default:    fix_cyc = 4'h1;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pc_next    = pc_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (o_issue && i_dec.cls inside {IPL_LOAD_MULTI, IPL_STORE_MULTI} && i_dec.cond_pass)
        begin
          pc_next = i_dec.has_pc && i_dec.cls == IPL_LOAD_MULTI;
          if (beats > 4'h1)
          begin
            state_next = ST_MULTI;
            cnt_next   = 4'(beats - 4'h1);
          end
          else if (pc_next)
          begin
            state_next = ST_REFILL;
            cnt_next   = IPL_REFILL_CYC;
          end
        end
        else if (o_issue && i_dec.cls == IPL_CP && !i_cp_ready)
          state_next = ST_COPROC;
        else if (o_issue && fix_cyc > 4'h1)
        begin
          state_next = ST_FIXED;
          cnt_next   = 4'(fix_cyc - 4'h1);
        end
      end
      ST_MULTI:
      begin
        if (cnt_reg == 4'h1)
        begin
          state_next = pc_reg ? ST_REFILL : ST_IDLE;
          cnt_next   = pc_reg ? IPL_REFILL_CYC : 4'h0;
        end
        else
          cnt_next = 4'(cnt_reg - 4'h1);
      end
      ST_REFILL,
      ST_FIXED:
      begin
        if (cnt_reg == 4'h1)
          state_next = ST_IDLE;
        cnt_next = 4'(cnt_reg - 4'h1);
      end
      ST_COPROC:
      begin
        if (i_cp_ready)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 4'h0;
      pc_reg     <= 1'b0;
      waited_reg <= 2'h0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      pc_reg     <= pc_next;
      waited_reg <= waited_next;
    end
  end

  // ---------------------------------------------------------------
  // Stage registers
  // ---------------------------------------------------------------
  // hold upstream, bubble downstream.
  always_ff @(posedge i_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      prev_reg <= '0;
      ex_reg   <= '0;
      mem_reg  <= '0;
    end
    else
    begin
      if (o_issue)
        prev_reg <= i_dec;
      if (!acc_hold)
        ex_reg <= o_issue ? i_dec : '0;
      mem_reg <= acc_hold ? '0 : ex_reg;
    end
  end

  // ---------------------------------------------------------------
  // Register bank and forwarding
  // ---------------------------------------------------------------
  logic [IPL_DATA_W-1:0] rb_a, rb_b, rb_st1, rb_st2;

  ipl_regbank #(
    .DEPTH (16),
    .WIDTH (IPL_DATA_W)
  ) u_regbank (
    .i_clk            (i_clk),
    .i_rd_idx_a       (i_dec.src_a),
    .i_rd_idx_b       (i_dec.src_b),
    .i_rd_idx_st1     (i_store_idx_first),
    .i_rd_idx_st2     (i_store_idx_second),
    .i_wr_alu         (i_alu_wr),
    .i_wr_load_first  (i_ldst_wr_first),
    .i_wr_load_second (i_ldst_wr_second),
    .o_rd_a           (rb_a),
    .o_rd_b           (rb_b),
    .o_rd_st1         (rb_st1),
    .o_rd_st2         (rb_st2)
  );

  // execute and memory forwarding.
  // The younger execute result takes priority over the memory one.
  wire ex_fwd_a  = ex_reg.valid  && is_dp(ex_reg.cls)  && ex_reg.dst == i_dec.src_a;
  wire ex_fwd_b  = ex_reg.valid  && is_dp(ex_reg.cls)  && ex_reg.dst == i_dec.src_b;
  wire mem_fwd_a = mem_reg.valid && mem_reg.dst == i_dec.src_a;
  wire mem_fwd_b = mem_reg.valid && mem_reg.dst == i_dec.src_b;
  wire [IPL_DATA_W-1:0] fwd_a = ex_fwd_a ? i_ex_result : mem_fwd_a ? i_mem_result : rb_a;
  wire [IPL_DATA_W-1:0] fwd_b = ex_fwd_b ? i_ex_result : mem_fwd_b ? i_mem_result : rb_b;

  // Operands are captured on issue and held through any execute hold.
  always_ff @(posedge i_clk or negedge rst_sync_n_reg)
  begin
    if (!rst_sync_n_reg)
    begin
      op_a_reg <= 32'h0000_0000;
      op_b_reg <= 32'h0000_0000;
      st1_reg  <= 32'h0000_0000;
      st2_reg  <= 32'h0000_0000;
    end
    else
    begin
      if (o_issue)
      begin
        op_a_reg <= fwd_a;
        op_b_reg <= fwd_b;
      end
      st1_reg <= rb_st1;
      st2_reg <= rb_st2;
    end
  end

  assign o_op_a              = op_a_reg;
  assign o_op_b              = op_b_reg;
  assign o_store_data_first  = st1_reg;
  assign o_store_data_second = st2_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_sync_n_reg);

  sequence refill_run_s;
    o_refill [*6] ##1 !o_refill;
  endsequence

  sequence byte_then_use_s;
    (o_issue && i_dec.cls == IPL_BYTE) ##1 (dp_hit && !fsm_busy && !acc_hold);
  endsequence

  lsm_hold_a: assert property ((o_lsm_active && i_dec.valid) |-> !o_issue)
    else $error("Instruction issued under an active multiple.");
  refill_len_a: assert property ($rose(o_refill) |-> refill_run_s)
    else $error("Pc refill did not last six cycles.");
  swap_drain_a: assert property ((i_dec.valid && i_dec.cls == IPL_SWAP && i_ldst_pending)
                                 |-> !o_issue)
    else $error("Swap issued with loads or stores outstanding.");
  swap_len_a: assert property ((o_issue && i_dec.cls == IPL_SWAP) |=> fsm_busy ##1 !fsm_busy)
    else $error("Swap did not occupy two cycles.");
  cp_wait_a: assert property ((state_reg == ST_COPROC && !i_cp_ready && i_dec.valid)
                              |-> o_stall_decode)
    else $error("Decode advanced while coprocessor busy.");
  blh_first_a: assert property ((o_issue && i_dec.cls == IPL_BLH1)
                                |=> fsm_busy [*2] ##1 !fsm_busy)
    else $error("First link half not three cycles.");
  trap_pass_a: assert property ((o_issue && i_dec.cls == IPL_SOFT_INT && i_dec.cond_pass)
                               |=> fsm_busy [*4] ##1 !fsm_busy)
    else $error("Passing software interrupt not five cycles.");
  mul_stage_a: assert property ((i_dec.valid && i_dec.cls == IPL_MUL && i_mul_head_busy)
                                |-> !o_issue)
    else $error("Multiply issued while multiplier first stage busy.");
  byte_use_a: assert property (byte_then_use_s |-> !o_issue ##1 !o_issue)
    else $error("Byte load user issued before two stall cycles.");
  bubble_a: assert property ((!o_issue && !o_ex_hold) |=> !o_ex_instr.valid)
    else $error("Execute stage not given a bubble during stall.");

endmodule : ipl_interlock

/* tb/ipl_partner.sv */
// Model of the load/store unit, multiplier and coprocessor around the
// interlock. Assumes the bench calls busy() between clock edges.
`timescale 1ns/100ps
module ipl_partner (
  input  wire logic i_clk,
  output logic      o_ldst_pending,
  output logic      o_mul_head_busy,
  output logic      o_acc_ready,
  output logic      o_cp_ready
);
  int ldst_reg = 0;
  int mul_reg = 0;
  int acc_reg = 0;
  int cp_reg  = 0;
  // Each unit reports busy until its commanded count has run out.
  // slow coprocessor
  assign o_cp_ready    = (cp_reg == 0);
  assign o_ldst_pending  = (ldst_reg != 0);
  assign o_mul_head_busy = (mul_reg != 0);
  assign o_acc_ready   = (acc_reg == 0);
  // Counts fall once per edge, so a slow unit never answers early.
  always @(posedge i_clk)
  begin
    ldst_reg <= (ldst_reg > 0) ? ldst_reg - 1 : 0;
    mul_reg <= (mul_reg > 0) ? mul_reg - 1 : 0;
    acc_reg <= (acc_reg > 0) ? acc_reg - 1 : 0;
    cp_reg  <= (cp_reg > 0) ? cp_reg - 1 : 0;
  end
  // Load the busy counts for the next scenario.
  task automatic busy(input int l, m, a, c);
    ldst_reg = l;
    mul_reg = m;
    acc_reg = a;
    cp_reg  = c;
  endtask : busy
endmodule : ipl_partner

/* tb/tb_top.sv */
// Self-checking bench for the interlock block.
// Assumes inputs change at the falling edge of the core clock.
`timescale 1ns/100ps
module tb_top;
  import ipl_pkg::*;
  logic        i_clk   = 1'b0;
  logic        i_rst_n = 1'b0;
  ipl_dec_type i_dec   = '0;
  ipl_dec_type nop     = '0;
  logic        pfu     = 1'b0;
  logic [31:0] ex_res  = '0;
  ipl_wr_type  wa      = '0;
  ipl_wr_type  wf      = '0;
  ipl_wr_type  ws      = '0;
  logic [3:0]  si1     = '0;
  logic [3:0]  si2     = '0;
  logic        o_issue;
  logic [31:0] op_a;
  ipl_dec_type ex_i;
  logic        refill;
  logic        hold;
  logic [31:0] sd1;
  logic [31:0] sd2;
  logic        ldst;
  logic        mul;
  logic        acc;
  logic        cp;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          nref = 0;
  int          nhold = 0;
  ipl_partner partner_i (.i_clk(i_clk), .o_ldst_pending(ldst), .o_mul_head_busy(mul),
    .o_acc_ready(acc), .o_cp_ready(cp));
  ipl_interlock ipl_interlock_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_dec(i_dec),
    .i_ldst_pending(ldst), .i_mul_head_busy(mul), .i_acc_ready(acc), .i_cp_ready(cp),
    .i_pfu_empty(pfu), .i_ex_result(ex_res), .i_mem_result(~ex_res), .i_alu_wr(wa),
    .i_ldst_wr_first(wf), .i_ldst_wr_second(ws), .i_store_idx_first(si1),
    .i_store_idx_second(si2), .o_issue(o_issue), .o_stall_decode(), .o_bubble(),
    .o_ex_hold(hold), .o_lsm_active(), .o_refill(refill), .o_ex_instr(ex_i),
    .o_op_a(op_a), .o_op_b(), .o_store_data_first(sd1), .o_store_data_second(sd2));
  // Refill and execute-hold cycles are counted where the outputs have settled.
  always @(negedge i_clk)
  begin
    nref  += int'(refill);
    nhold += int'(hold);
  end
  // Core clock; a hang is cut short after a fixed budget of cycles.
  initial
  begin
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Flags are aligned, has_pc, cond_pass, folded, acc_dep.
  function automatic ipl_dec_type mk(ipl_cls_type c, logic [3:0] a, d, logic [4:0] n, f);
    return '{1'b1, c, a, 4'hF, d, n, f[4], f[3], f[2], f[1], f[0]};
  endfunction : mk
  // Count cycles until the presented instruction issues, then step on.
  task automatic issue(output int n);
    n = 0;
    #1;
    while (o_issue !== 1'b1 && n < 60)
    begin
      @(negedge i_clk);
      #1;
      n++;
    end
    @(negedge i_clk);
  endtask : issue
  // Issue a, then b right behind it, and count the cycles between them.
  // One idle cycle follows, so that the next scenario starts on a fresh edge.
  task automatic gap(input ipl_dec_type a, b, input int ew, eg);
    int w;
    int g;
    i_dec = a;
    issue(w);
    i_dec = b;
    issue(g);
    i_dec.valid = 1'b0;
    check(w, ew);
    check(g + 1, eg);
    check(32'(ex_i), 32'(b));
    @(negedge i_clk);
  endtask : gap
  // Bank writes on all three ports, then reads through the store ports and port A.
  task automatic bank();
    wa = '{1'b1, 4'h7, 32'h0000_0A11};
    wf = '{1'b1, 4'h8, 32'h0000_0B22};
    ws = '{1'b1, 4'h9, 32'h0000_0C33};
    @(negedge i_clk);
    wa.idx = 4'hA;
    wf.idx = 4'hA;
    ws.idx = 4'hA;
    @(negedge i_clk);
    wa = '0;
    wf = '0;
    ws = '0;
    si1 = 4'h7;
    si2 = 4'h8;
    repeat (2) @(negedge i_clk);
    check(sd1, 32'h0000_0A11);
    check(sd2, 32'h0000_0B22);
    si1 = 4'h9;
    si2 = 4'hA;
    repeat (2) @(negedge i_clk);
    check(sd1, 32'h0000_0C33);
    check(sd2, 32'h0000_0C33);
    i_dec = mk(IPL_DP, 4'h7, 4'h1, 5'h1, 5'b00100);
    @(negedge i_clk);
    i_dec.valid = 1'b0;
    check(op_a, 32'h0000_0A11);
  endtask : bank
  // Main sequence.
  initial
  begin
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    nop = mk(IPL_DP, 4'hF, 4'hE, 5'h1, 5'b00100);
    gap(mk(IPL_BLH1, 4'h1, 4'h0, 5'h1, 5'b00100), nop, 0, 3);
    gap(mk(IPL_BLH2, 4'h1, 4'h0, 5'h1, 5'b00100), nop, 0, 4);
    gap(mk(IPL_SOFT_INT, 4'h1, 4'h0, 5'h1, 5'b00100), nop, 0, 5);
    gap(mk(IPL_SOFT_INT, 4'h1, 4'h0, 5'h1, 5'b00000), nop, 0, 2);
    pfu = 1'b1;
    gap(mk(IPL_BRANCH, 4'h1, 4'h0, 5'h1, 5'b00110), nop, 0, 1);
    gap(mk(IPL_BRANCH, 4'h1, 4'h0, 5'h1, 5'b00100), nop, 0, 3);
    pfu = 1'b0;
    gap(mk(IPL_LOAD_MULTI, 4'h1, 4'h0, 5'h4, 5'b10100), nop, 0, 2);
    gap(mk(IPL_LOAD_MULTI, 4'h1, 4'h0, 5'h4, 5'b00100), nop, 0, 3);
    gap(mk(IPL_LOAD_MULTI, 4'h1, 4'h0, 5'h4, 5'b11100), nop, 0, 8);
    check(nref, 6);
    gap(mk(IPL_STORE_MULTI, 4'h1, 4'h0, 5'h5, 5'b10100), nop, 0, 3);
    gap(mk(IPL_LOAD_MULTI, 4'h1, 4'h0, 5'h6, 5'b10100),
        mk(IPL_LOAD, 4'hD, 4'hC, 5'h1, 5'b00100), 0, 3);
    gap(mk(IPL_LOAD, 4'h1, 4'h3, 5'h1, 5'b00100), mk(IPL_DP, 4'h3, 4'hE, 5'h1, 5'b00100),
        0, 2);
    gap(mk(IPL_BYTE, 4'h1, 4'h3, 5'h1, 5'b00100), mk(IPL_DP, 4'h3, 4'hE, 5'h1, 5'b00100),
        0, 3);
    gap(mk(IPL_DP, 4'h1, 4'h3, 5'h1, 5'b00100), mk(IPL_LOAD, 4'h3, 4'hC, 5'h1, 5'b00100),
        0, 2);
    gap(mk(IPL_LOAD, 4'h1, 4'h3, 5'h1, 5'b00100), mk(IPL_STORE, 4'h3, 4'hC, 5'h1, 5'b00100),
        0, 3);
    ex_res = 32'hA5A5_0001;
    gap(mk(IPL_DP, 4'h1, 4'h3, 5'h1, 5'b00100), mk(IPL_DP, 4'h3, 4'hE, 5'h1, 5'b00100),
        0, 1);
    check(op_a, 32'hA5A5_0001);
    partner_i.busy(4, 0, 0, 0);
    gap(mk(IPL_SWAP, 4'h1, 4'h0, 5'h1, 5'b00100), nop, 4, 2);
    partner_i.busy(0, 2, 0, 0);
    gap(mk(IPL_MUL, 4'h1, 4'h0, 5'h1, 5'b00100), nop, 2, 1);
    partner_i.busy(0, 0, 3, 0);
    gap(mk(IPL_MAC, 4'h1, 4'h0, 5'h1, 5'b00101), nop, 0, 3);
    check(nhold, 2);
    partner_i.busy(0, 0, 0, 3);
    gap(mk(IPL_CP, 4'h1, 4'h0, 5'h1, 5'b00100), nop, 0, 4);
    bank();
    complete_run();
  end
endmodule : tb_top
